/* verilog/smc_pkg.sv */
// Operation
// RULE1: one active mode plus idle, standby, power-down, each entered straight from active.
// RULE2: sleep only when the sleep instruction executes with enable flag set.
// RULE3: software arms wake interrupts and global enable before programming and sleeping.
// RULE4: interrupt wake runs the service routine, then resumes after the sleep instruction.
// RULE5: any reset during sleep ends it; execution restarts at the reset vector.
// RULE6: register file, memory and peripheral registers keep their contents while asleep.
// RULE7: no enabled interrupt at entry means only reset can wake the device; the code also wakes on a debug break.
// RULE8: debug break while asleep forces active mode, pending interrupt or not.
// RULE9: idle stops the cpu, peripherals keep running, every interrupt can wake.
// RULE10: in standby a peripheral runs and wakes only with its run-in-standby bit set.
// RULE11: standby wakes from pins, two-wire match, timer b, and gated serial, converter, counter; the code also lets the periodic timer wake standby.
// RULE12: in standby the converter may run on its own without waking the cpu.
// RULE13: power-down keeps only watchdog and periodic timer; wakes on pin change, two-wire match.
// RULE14: power-down stops every clock source except low-power 32 kHz and watchdog source.
// RULE15: wake latency is six peripheral clocks plus main oscillator start-up.
// RULE16: waking from idle adds no oscillator start-up delay.
// RULE17: with brown-out config 0x3, resume waits for brown-out ready if that is later.
// RULE18: mode field encodes idle 0x0, standby 0x1, power-down 0x2; 0x3 reserved.
// RULE19: control register at 0x00 resets to 0x00; enable bit 0, mode bits 2:1.
// RULE20: cpu clock is gated in every sleep mode until the wake latency has elapsed.
package smc_pkg;
	localparam logic [7:0] SMC_CTRL_OFFSET = 8'h00;
	localparam logic [7:0] SMC_CTRL_RESET = 8'h00;
	localparam int SMC_ENABLE_BIT = 0;
	localparam int SMC_MODE_LSB = 1;
	localparam int SMC_MODE_MSB = 2;
	localparam logic [1:0] SMC_MODE_IDLE = 2'h0;
	localparam logic [1:0] SMC_MODE_STANDBY = 2'h1;
	localparam logic [1:0] SMC_MODE_DEEP = 2'h2;
	localparam logic [1:0] SMC_BOD_WAIT_CFG = 2'h3;
	localparam int SMC_WAKE_CLK = 6;
	localparam logic [3:0] SMC_WAKE_CYCLES = 4'(SMC_WAKE_CLK);

	typedef enum logic [2:0]
	{
		SMC_ACTIVE,
		SMC_SLEEPING,
		SMC_OSC_WAIT,
		SMC_WAKE_COUNT,
		SMC_BOD_WAIT
	} smc_state_type;

	// wake request lines from the peripherals
	typedef struct packed
	{
		logic pin_irq;
		logic two_wire_port_match;
		logic timer_type_b_irq;
		logic serial_sof_irq;
		logic adc_window_irq;
		logic rtc_irq;
		logic periodic_interrupt_timer_irq;
		logic other_irq;
	} smc_wake_type;

	// run-in-standby settings of the peripherals
	typedef struct packed
	{
		logic serial;
		logic adc;
		logic rtc;
		logic main_osc;
	} smc_stby_type;

	// clock and domain enables handed to the clock tree
	typedef struct packed
	{
		logic cpu;
		logic periph;
		logic rtc;
		logic adc;
		logic periodic_interrupt_timer;
		logic watchdog_unit;
		logic main_osc;
		logic ulp_osc;
	} smc_gate_type;
endpackage

/* verilog/smc_sleep_ctrl.sv */
`timescale 1ns/1ns
module smc_sleep_ctrl
(
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// control register write port
	input wire logic ctrl_write,
	input wire logic [7:0] ctrl_wdata,
	output logic [7:0] sleep_control_register,
	// cpu side
	input wire logic sleep_instr,
	input wire logic global_irq_en,
	input wire logic debug_break,
	output logic cpu_halted,
	output logic wake_by_irq,
	// wake sources and standby settings
	input wire smc_pkg::smc_wake_type wake_req,
	input wire smc_pkg::smc_wake_type wake_en,
	input wire smc_pkg::smc_stby_type run_in_standby,
	// oscillator and brown-out status
	input wire logic main_osc_ready,
	input wire logic [1:0] brownout_active_cfg,
	input wire logic brownout_ready,
	// domain gates and status
	output smc_pkg::smc_gate_type clock_gate,
	output logic [1:0] active_mode,
	output logic asleep
);
	import smc_pkg::*;

	smc_state_type state;
	smc_state_type next_state;
	logic sleep_enable_flag;
	logic [1:0] sleep_mode_select;
	logic [1:0] sleep_mode;
	logic [3:0] wake_count;
	logic irq_armed;
	logic irq_wake;
	smc_wake_type qual;
	smc_gate_type next_gate;
	logic [1:0] gate_mode;

	// which wake sources count in a given mode
	function automatic smc_wake_type wake_mask(input logic [1:0] mode, input smc_stby_type rs);
		smc_wake_type m;
		m = '0;
		unique case (mode)
			SMC_MODE_IDLE:
				m = '1; // RULE9
			SMC_MODE_STANDBY:
			begin
				m.pin_irq = 1'b1; // RULE11
				m.two_wire_port_match = 1'b1;
				m.timer_type_b_irq = 1'b1;
				m.periodic_interrupt_timer_irq = 1'b1;
				m.serial_sof_irq = rs.serial; // RULE10
				m.adc_window_irq = rs.adc;
				m.rtc_irq = rs.rtc;
			end
			default:
			begin
				m.pin_irq = 1'b1; // RULE13
				m.two_wire_port_match = 1'b1;
			end
		endcase
		return m;
	endfunction

	// control register; reserved code 0x3 stored but treated as power-down
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			sleep_enable_flag <= SMC_CTRL_RESET[SMC_ENABLE_BIT]; // RULE19
			sleep_mode_select <= SMC_CTRL_RESET[SMC_MODE_MSB:SMC_MODE_LSB];
		end
		else if (clk_en && ctrl_write)
		begin
			sleep_enable_flag <= ctrl_wdata[SMC_ENABLE_BIT];
			sleep_mode_select <= ctrl_wdata[SMC_MODE_MSB:SMC_MODE_LSB]; // RULE18
		end
	end

	assign sleep_control_register = {5'h0_0, sleep_mode_select, sleep_enable_flag}; // RULE19

	// qualified wake: enabled, allowed in this mode, and global irq armed at entry
	assign qual = wake_req & wake_en & wake_mask(sleep_mode, run_in_standby);
	assign irq_wake = irq_armed && (|qual); // RULE7

	// sleep state machine; reset or a debug break is the only way out when nothing is armed
	always_comb
	begin
		next_state = state;
		unique case (state)
			SMC_ACTIVE:
				if (sleep_instr && sleep_enable_flag)
					next_state = SMC_SLEEPING; // RULE1 RULE2
			SMC_SLEEPING:
				if (irq_wake || debug_break) // RULE8
				begin
					if (sleep_mode == SMC_MODE_IDLE || (sleep_mode == SMC_MODE_STANDBY && run_in_standby.main_osc))
						next_state = SMC_WAKE_COUNT; // RULE16
					else
						next_state = SMC_OSC_WAIT; // RULE15
				end
			SMC_OSC_WAIT:
				if (main_osc_ready)
					next_state = SMC_WAKE_COUNT; // RULE15
			SMC_WAKE_COUNT:
				if (wake_count == SMC_WAKE_CYCLES - 4'h1)
					next_state = (brownout_active_cfg == SMC_BOD_WAIT_CFG && !brownout_ready) ?
						SMC_BOD_WAIT : SMC_ACTIVE; // RULE17
			SMC_BOD_WAIT:
				if (brownout_ready)
					next_state = SMC_ACTIVE; // RULE17
			default:
				next_state = SMC_ACTIVE;
		endcase
	end

	// state register; synchronous reset ends any sleep
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			state <= SMC_ACTIVE; // RULE5
		else if (clk_en)
			state <= next_state;
	end

	// latch mode and irq arming at entry so mid-sleep writes do not move the wake set
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			sleep_mode <= SMC_MODE_IDLE;
			irq_armed <= 1'b0;
		end
		else if (clk_en && state == SMC_ACTIVE && next_state == SMC_SLEEPING)
		begin
			sleep_mode <= sleep_mode_select;
			irq_armed <= global_irq_en; // RULE7
		end
	end

	// six peripheral clocks of wake latency
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			wake_count <= 4'h0;
		else if (clk_en)
			wake_count <= (state == SMC_WAKE_COUNT) ? wake_count + 4'h1 : 4'h0; // RULE15
	end

	// remember whether the wake came from an interrupt so the cpu enters the handler
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			wake_by_irq <= 1'b0;
		else if (clk_en)
		begin
			if (state == SMC_SLEEPING && next_state != SMC_SLEEPING)
				wake_by_irq <= irq_wake; // RULE4
			else if (state == SMC_ACTIVE && next_state == SMC_SLEEPING)
				wake_by_irq <= 1'b0;
		end
	end

	// gates follow the live field only at entry; asleep they use the latched mode so a write cannot move them
	assign gate_mode = (state == SMC_ACTIVE) ? sleep_mode_select : sleep_mode;

	// domain gates; registers elsewhere are never reset here, so contents survive
	always_comb
	begin
		next_gate = '1;
		if (next_state != SMC_ACTIVE)
		begin
			next_gate.cpu = 1'b0; // RULE20 RULE6
			unique case (gate_mode)
				SMC_MODE_IDLE:
					next_gate.cpu = 1'b0; // RULE9
				SMC_MODE_STANDBY:
				begin
					next_gate.periph = 1'b0; // RULE10
					next_gate.rtc = run_in_standby.rtc;
					next_gate.adc = run_in_standby.adc; // RULE12
					next_gate.main_osc = run_in_standby.main_osc;
				end
				default:
				begin
					next_gate.periph = 1'b0; // RULE13
					next_gate.rtc = 1'b0;
					next_gate.adc = 1'b0;
					next_gate.main_osc = 1'b0; // RULE14
				end
			endcase
			if (state != SMC_ACTIVE && state != SMC_SLEEPING)
				next_gate.main_osc = 1'b1; // oscillator restarts during wake
			if (state != SMC_ACTIVE)
			begin
				if (sleep_mode == SMC_MODE_IDLE)
					next_gate.periph = 1'b1;
			end
		end
	end

	// registered gate outputs
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			clock_gate <= '1;
		else if (clk_en)
			clock_gate <= next_gate; // RULE20
	end

	// status outputs
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			cpu_halted <= 1'b0;
			asleep <= 1'b0;
			active_mode <= SMC_MODE_IDLE;
		end
		else if (clk_en)
		begin
			cpu_halted <= (next_state != SMC_ACTIVE); // RULE20
			asleep <= (next_state == SMC_SLEEPING);
			if (state == SMC_ACTIVE && next_state == SMC_SLEEPING)
				active_mode <= sleep_mode_select;
		end
	end

	// checks
	sleep_needs_en_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && state == SMC_ACTIVE && next_state == SMC_SLEEPING |-> sleep_enable_flag && sleep_instr)
		else $error("sleep entered without enable"); // RULE2
	reset_ends_a: assert property (@(posedge ref_clk) !reset_n |=> state == SMC_ACTIVE)
		else $error("reset did not end sleep"); // RULE5
	wake_six_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && state == SMC_SLEEPING && next_state == SMC_WAKE_COUNT ##1 clk_en[*6] |->
		state != SMC_ACTIVE)
		else $error("wake shorter than six clocks"); // RULE15
	idle_fast_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == SMC_SLEEPING && sleep_mode == SMC_MODE_IDLE |-> next_state != SMC_OSC_WAIT)
		else $error("idle waited for oscillator"); // RULE16
	break_wakes_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && state == SMC_SLEEPING && debug_break |=> state != SMC_SLEEPING)
		else $error("debug break ignored"); // RULE8
	no_arm_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == SMC_SLEEPING && !irq_armed && !debug_break |-> next_state == SMC_SLEEPING)
		else $error("woke with no armed irq"); // RULE7
	cpu_gated_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		asleep |-> !clock_gate.cpu && cpu_halted)
		else $error("cpu clock running asleep"); // RULE20
	deep_osc_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		asleep && active_mode == SMC_MODE_DEEP |-> !clock_gate.main_osc && clock_gate.ulp_osc)
		else $error("oscillator left on in power-down"); // RULE14
	bod_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == SMC_BOD_WAIT && !brownout_ready |=> state != SMC_ACTIVE)
		else $error("resumed before brown-out ready"); // RULE17
	// control register comes back to its reset value
	reg_reset_a: assert property (@(posedge ref_clk) !reset_n |=> sleep_control_register == SMC_CTRL_RESET)
		else $error("control register not reset"); // RULE19
	// a low clock enable must hold the state, the wake count and the control register
	freeze_state_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!clk_en |=> $stable(state) && $stable(wake_count) && $stable(sleep_control_register))
		else $error("state moved with clock enable low");
	// idle keeps the peripheral domain running
	idle_periph_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		asleep && active_mode == SMC_MODE_IDLE |-> clock_gate.periph)
		else $error("peripherals stopped in idle"); // RULE9
	// watchdog and periodic timer never lose their clocks
	deep_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		asleep |-> clock_gate.watchdog_unit && clock_gate.periodic_interrupt_timer)
		else $error("watchdog or periodic timer gated"); // RULE13
	// power-down refuses timer b, serial, converter, counter and other wake sources
	deep_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == SMC_SLEEPING && sleep_mode == SMC_MODE_DEEP |->
		!(qual.timer_type_b_irq || qual.serial_sof_irq || qual.adc_window_irq || qual.rtc_irq || qual.other_irq))
		else $error("power-down woke from a barred source"); // RULE13
	// the latency counter never runs past its end
	wake_count_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == SMC_WAKE_COUNT |-> wake_count < SMC_WAKE_CYCLES)
		else $error("wake counter overran"); // RULE15
	// an interrupt wake is flagged for the handler
	irq_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && state == SMC_SLEEPING && irq_wake |=> wake_by_irq)
		else $error("interrupt wake not flagged"); // RULE4
	// entry halts the cpu on the next edge
	entry_halt_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && state == SMC_ACTIVE && next_state == SMC_SLEEPING |=> cpu_halted && asleep && !clock_gate.cpu)
		else $error("cpu not halted at entry"); // RULE20
	// mode is captured as written at entry
	entry_latch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && state == SMC_ACTIVE && next_state == SMC_SLEEPING |=> sleep_mode == $past(sleep_mode_select))
		else $error("mode not latched at entry"); // RULE18
	// no counting until the oscillator is usable
	osc_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == SMC_OSC_WAIT && !main_osc_ready |=> state == SMC_OSC_WAIT)
		else $error("count began before oscillator ready"); // RULE15
	// reserved mode behaves as power-down
	reserved_deep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		asleep && active_mode == 2'h3 |-> !clock_gate.main_osc && !clock_gate.periph)
		else $error("reserved mode left clocks on"); // RULE18
	// a ready monitor adds nothing to the normal latency
	bod_skip_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && state == SMC_WAKE_COUNT && wake_count == SMC_WAKE_CYCLES - 4'h1 && brownout_ready |=>
		state == SMC_ACTIVE)
		else $error("resume delayed with monitor ready"); // RULE17
	stby_cov: cover property (@(posedge ref_clk) state == SMC_SLEEPING && sleep_mode == SMC_MODE_STANDBY
		##[1:40] state == SMC_ACTIVE);
	idle_cov: cover property (@(posedge ref_clk) state == SMC_SLEEPING && sleep_mode == SMC_MODE_IDLE
		##[1:20] state == SMC_ACTIVE);
	deep_cov: cover property (@(posedge ref_clk) state == SMC_OSC_WAIT ##[1:40] state == SMC_ACTIVE);
	bod_cov: cover property (@(posedge ref_clk) state == SMC_BOD_WAIT);
endmodule

/* tb/smc_cpu_model.sv */
`timescale 1ns/1ns
module smc_cpu_model
#(
	parameter int OSC_START = 12
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// control register and sleep instruction
	output logic ctrl_write,
	output logic [7:0] ctrl_wdata,
	output logic sleep_instr,
	// main oscillator handshake
	input wire logic main_osc_on,
	output logic main_osc_ready
);
	int osc_cnt;
	initial
	begin
		ctrl_write = 1'b0;
		ctrl_wdata = 8'h00;
		sleep_instr = 1'b0;
	end
	// a gated oscillator is never usable at once; it needs a start-up count
	always @(posedge ref_clk)
	begin
		if (!reset_n || !main_osc_on)
			osc_cnt <= 0;
		else if (osc_cnt < OSC_START)
			osc_cnt <= osc_cnt + 1;
	end
	assign main_osc_ready = (osc_cnt >= OSC_START);
	// mode and enable go in first, the sleep instruction follows
	task automatic do_sleep(input logic [1:0] mode, input logic en);
		@(posedge ref_clk);
		ctrl_write <= 1'b1;
		ctrl_wdata <= {5'h00, mode, en};
		@(posedge ref_clk);
		ctrl_write <= 1'b0;
		sleep_instr <= 1'b1;
		@(posedge ref_clk);
		sleep_instr <= 1'b0;
	endtask
endmodule

/* tb/smc_sleep_ctrl_tb.sv */
`timescale 1ns/1ns
module smc_sleep_ctrl_tb;
	import smc_pkg::*;
	localparam int FAST = SMC_WAKE_CLK + 1;
	logic clk_en = 1'b1;
	smc_wake_type wake_en = '1;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic ctrl_write, sleep_instr, cpu_halted, wake_by_irq, main_osc_ready, asleep;
	logic global_irq_en = 1'b1;
	logic debug_break = 1'b0;
	logic brownout_ready = 1'b1;
	logic [1:0] brownout_active_cfg = 2'h0;
	logic [7:0] ctrl_wdata, sleep_control_register;
	logic [1:0] active_mode;
	smc_wake_type wake_req = '0;
	smc_stby_type run_in_standby = '0;
	smc_gate_type clock_gate;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;
	int lat;
	always #20 ref_clk = ~ref_clk;
	smc_cpu_model i_smc_cpu_model (.ref_clk(ref_clk), .reset_n(reset_n), .ctrl_write(ctrl_write),
		.ctrl_wdata(ctrl_wdata), .sleep_instr(sleep_instr), .main_osc_on(clock_gate.main_osc),
		.main_osc_ready(main_osc_ready));
	smc_sleep_ctrl i_smc_sleep_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
		.ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata), .sleep_control_register(sleep_control_register),
		.sleep_instr(sleep_instr), .global_irq_en(global_irq_en), .debug_break(debug_break),
		.cpu_halted(cpu_halted), .wake_by_irq(wake_by_irq), .wake_req(wake_req), .wake_en(wake_en),
		.run_in_standby(run_in_standby), .main_osc_ready(main_osc_ready),
		.brownout_active_cfg(brownout_active_cfg), .brownout_ready(brownout_ready),
		.clock_gate(clock_gate), .active_mode(active_mode), .asleep(asleep));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// a hung wait would otherwise run forever
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			end_sim();
		end
	end
	// sleep, raise one source, time the cpu's return; a stuck sleep is ended by a debug break
	task automatic nap(input logic [1:0] mode, input smc_wake_type src);
		i_smc_cpu_model.do_sleep(mode, 1'b1);
		@(posedge ref_clk);
		#1;
		chk("asleep", 8'h01, 8'(asleep));
		chk("cpu gate", 8'h00, 8'(clock_gate.cpu));
		chk("mode", 8'(mode), 8'(active_mode));
		chk("wdt gate", 8'h01, 8'(clock_gate.watchdog_unit));
		if (mode == SMC_MODE_IDLE)
			chk("periph gate", 8'h01, 8'(clock_gate.periph));
		if (mode == SMC_MODE_DEEP)
			chk("osc gate", 8'h00, 8'(clock_gate.main_osc));
		@(posedge ref_clk);
		wake_req <= src;
		lat = 0;
		while (cpu_halted !== 1'b0 && lat < 60)
		begin
			@(posedge ref_clk);
			#1;
			lat++;
		end
		if (lat == 60)
		begin
			@(posedge ref_clk);
			debug_break <= 1'b1;
			repeat (60) @(posedge ref_clk);
			#1;
			chk("debug wake", 8'h00, 8'(cpu_halted));
		end
		chk("irq flag", 8'(lat < 60), 8'(wake_by_irq));
		chk("ctrl kept", {5'h00, mode, 1'b1}, sleep_control_register);
		@(posedge ref_clk);
		wake_req <= '0;
		debug_break <= 1'b0;
	endtask
	initial
	begin
		void'($urandom(64527));
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk("reset reg", SMC_CTRL_RESET, sleep_control_register);
		chk("reset gates", 8'hFF, clock_gate);
		i_smc_cpu_model.do_sleep(SMC_MODE_DEEP, 1'b0);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("flag off", 8'h00, 8'(asleep));
		chk("reg write", 8'h04, sleep_control_register);
		@(posedge ref_clk);
		clk_en <= 1'b0;
		i_smc_cpu_model.do_sleep(SMC_MODE_IDLE, 1'b1);
		@(posedge ref_clk);
		#1;
		chk("frozen asleep", 8'h00, 8'(asleep));
		chk("frozen reg", 8'h04, sleep_control_register);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		$display("test reset and enable flag done");
		for (int i = 0; i < 6; i++)
		begin
			nap(SMC_MODE_IDLE, smc_wake_type'(8'h01 << ($urandom % 8)));
			chk("idle lat", 8'(FAST), 8'(lat));
		end
		$display("test idle done");
		@(posedge ref_clk);
		run_in_standby <= smc_stby_type'(4'h1);
		nap(SMC_MODE_STANDBY, smc_wake_type'(8'h80));
		chk("stby osc on", 8'(FAST), 8'(lat));
		run_in_standby <= smc_stby_type'(4'h0);
		nap(SMC_MODE_STANDBY, smc_wake_type'(8'h20));
		chk("stby slow", 8'h01, 8'(lat > FAST && lat < 60));
		nap(SMC_MODE_STANDBY, smc_wake_type'(8'h04));
		chk("rtc off", 8'd60, 8'(lat));
		run_in_standby <= smc_stby_type'(4'h2);
		nap(SMC_MODE_STANDBY, smc_wake_type'(8'h04));
		chk("rtc on", 8'h01, 8'(lat < 60));
		$display("test standby done");
		nap(SMC_MODE_DEEP, smc_wake_type'(8'h01));
		chk("deep other", 8'd60, 8'(lat));
		nap(SMC_MODE_DEEP, smc_wake_type'(8'h80));
		chk("deep pin", 8'h01, 8'(lat > FAST && lat < 60));
		nap(2'h3, smc_wake_type'(8'h40));
		chk("reserved", 8'h01, 8'(lat > FAST && lat < 60));
		$display("test power-down done");
		global_irq_en <= 1'b0;
		nap(SMC_MODE_IDLE, smc_wake_type'(8'h80));
		chk("no irq en", 8'd60, 8'(lat));
		global_irq_en <= 1'b1;
		wake_en <= smc_wake_type'(8'h7F);
		nap(SMC_MODE_IDLE, smc_wake_type'(8'h80));
		chk("masked src", 8'd60, 8'(lat));
		wake_en <= '1;
		brownout_active_cfg <= SMC_BOD_WAIT_CFG;
		brownout_ready <= 1'b0;
		fork
			begin
				repeat (30) @(posedge ref_clk);
				brownout_ready <= 1'b1;
			end
		join_none
		nap(SMC_MODE_IDLE, smc_wake_type'(8'h40));
		chk("bod wait", 8'h01, 8'(lat > FAST && lat < 60));
		$display("test irq enable and brown-out done");
		i_smc_cpu_model.do_sleep(SMC_MODE_STANDBY, 1'b1);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		@(posedge ref_clk);
		reset_n <= 1'b1;
		#1;
		chk("reset wake", 8'h00, {6'h00, asleep, cpu_halted});
		chk("reset reg", 8'h00, sleep_control_register);
		$display("test reset in sleep done");
		end_sim();
	end
endmodule
